// ### shared/rac_pkg.sv
/*
 * Constants and types for the receive alarm, code and status register group.
 * Assumes a byte-wide register port and a 125 MHz device clock.
 */
package rac_pkg;
   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] RAC_OFS_SA_IRQ_MASK  = 8'ha6;
   localparam logic [7:0] RAC_OFS_SIG_EN_1     = 8'ha8;
   localparam logic [7:0] RAC_OFS_SIG_EN_2     = 8'ha9;
   localparam logic [7:0] RAC_OFS_SIG_EN_3     = 8'haa;
   localparam logic [7:0] RAC_OFS_SIG_EN_4     = 8'hab;
   localparam logic [7:0] RAC_OFS_LUP_1        = 8'hac;
   localparam logic [7:0] RAC_OFS_LUP_2        = 8'had;
   localparam logic [7:0] RAC_OFS_LDN_1        = 8'hae;
   localparam logic [7:0] RAC_OFS_LDN_2        = 8'haf;
   localparam logic [7:0] RAC_OFS_LIVE_ALARM   = 8'hb0;
   localparam logic [7:0] RAC_OFS_LIVE_CODE    = 8'hb2;
   localparam logic [7:0] RAC_OFS_LIVE_HDLC    = 8'hb4;
   localparam logic [7:0] RAC_OFS_BYTES_AVAIL  = 8'hb5;
   localparam logic [7:0] RAC_REG_RESET        = 8'h00;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int RAC_BIT_BOC_EN    = 0;
   localparam int RAC_BIT_SA_CHG_EN = 0;
   localparam int RAC_BIT_SA6_EN    = 1;
   localparam int RAC_BIT_RAI       = 3;
   localparam int RAC_BIT_AIS       = 2;
   localparam int RAC_BIT_LOS       = 1;
   localparam int RAC_BIT_LOF       = 0;
   localparam int RAC_BIT_RX_CLOCK_LOSS_LIVE      = 3;
   localparam int RAC_BIT_LSP       = 2;
   localparam int RAC_BIT_LDN       = 1;
   localparam int RAC_BIT_LUP       = 0;
   localparam int RAC_BIT_V52       = 1;
   localparam int RAC_BIT_DISTANT_MF_ALARM_LIVE      = 0;
   localparam int RAC_BIT_PS_LO     = 4;
   localparam int RAC_BIT_HWM       = 1;
   localparam int RAC_BIT_NE        = 0;
   localparam int RAC_BIT_MS        = 7;
   localparam int RAC_T1_CHANNELS   = 24;

   // ------------------------------------------------------------------
   // packet status codes
   // ------------------------------------------------------------------
   localparam logic [2:0] RAC_PS_IN_PROGRESS = 3'h0;
   localparam logic [2:0] RAC_PS_GOOD        = 3'h1;
   localparam logic [2:0] RAC_PS_CRC_ERR     = 3'h2;
   localparam logic [2:0] RAC_PS_ABORT       = 3'h3;
   localparam logic [2:0] RAC_PS_OVERRUN     = 3'h4;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int RAC_CLK_PERIOD_NS   = 8;
   localparam int RAC_T1_CHAN_TIME_NS = 5181;
   localparam int RAC_E1_CHAN_TIME_NS = 3906;
   localparam int RAC_T1_CHAN_CYCLES  =
      (RAC_T1_CHAN_TIME_NS + RAC_CLK_PERIOD_NS - 1) / RAC_CLK_PERIOD_NS;
   localparam int RAC_E1_CHAN_CYCLES  =
      (RAC_E1_CHAN_TIME_NS + RAC_CLK_PERIOD_NS - 1) / RAC_CLK_PERIOD_NS;
   localparam int RAC_LOS_ZEROS       = 192;
   localparam int RAC_DMA_MULTIFRAMES = 2;
   localparam int RAC_NUM_CODES       = 3;
   localparam int RAC_CODE_LUP        = 0;
   localparam int RAC_CODE_LDN        = 1;
   localparam int RAC_CODE_SPARE      = 2;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rac_bus_type;

   typedef struct packed {
      logic remote_alarm;
      logic all_ones;
      logic frame_loss;
      logic v52_link;
      logic bit_valid;
      logic bit_value;
      logic mf_valid;
      logic mf_ts16_bit6;
   } rac_line_type;

   typedef struct packed {
      logic [7:0]                    mask7;
      logic [3:0][7:0]               sig_en;
      logic [7:0]                    lup1;
      logic [7:0]                    lup2;
      logic [7:0]                    ldn1;
      logic [7:0]                    ldn2;
      logic [7:0]                    los_cnt;
      logic [9:0]                    rx_clock_loss_live_cnt;
      logic                          clk_prev;
      logic [RAC_NUM_CODES-1:0][15:0] code_cnt;
      logic [RAC_NUM_CODES-1:0][3:0]  code_phase;
      logic [1:0]                    dma_cnt;
      logic [2:0]                    pkt_state;
      logic [7:0]                    rdata;
      logic                          sig_flag;
      logic                          boc_irq;
      logic                          sa6_irq;
      logic                          sa_chg_irq;
   } rac_state_type;
endpackage

// ### verilog/rac_regs.sv
/*
 * Receive-side alarm, loop code and HDLC status register group of one port.
 * Assumes framer, HDLC controller and line sampler deliver synchronous
 * strobes and levels on clk; the host port is a byte-wide strobe port.
 */
// Overview of operation
// - T1 mask bit 0 gates code-detect interrupt
// - E1 mask bit 1 gates Sa6 codeword interrupt
// - E1 mask bit 0 gates unmasked Sa changes
// - enabled channel signaling change sets change flag, in T1 only for channels below 24
// - first pattern byte MSB first, tail ignored
// - second pattern byte ignored for short lengths
// - writing first pattern byte restarts integration
// - live status bits follow conditions, unlatched, except the packet state held from the last FIFO read
// - live bit 3 shows remote alarm
// - live bit 2 shows unframed all ones
// - live bit 1 after 192 zeros
// - live bit 0 shows loss of frame
// - clock loss after one silent channel time
// - T1 bit 2 shows spare code received
// - T1 bit 1 shows loop-down code received
// - E1 bit 1 shows V5.2 link
// - E1 distant alarm after two multiframes
// - packet state captured at each FIFO read
// - high water bit when count exceeds mark
// - not-empty bit while bytes are readable
// - message bit low marks end, high otherwise
// - low seven bits give bytes available
module rac_regs
   import rac_pkg::*;
#(
   parameter int CODE_INTEG_BITS = 48
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              e1_mode,
   input  wire rac_bus_type       bus,
   output logic [7:0]             rdata,
   input  wire rac_line_type      line,
   input  wire logic              line_rx_clock_pin,
   input  wire logic [4:0]        code_len_sel,
   input  wire logic [7:0]        spare_pattern_1,
   input  wire logic [7:0]        spare_pattern_2,
   input  wire logic              sig_chg_valid,
   input  wire logic [4:0]        sig_chg_chan,
   output logic                   sig_change_flag,
   input  wire logic              boc_event,
   input  wire logic              sa6_event,
   input  wire logic [7:0]        sa_change_vec,
   input  wire logic [7:0]        sa_bit_mask_reg,
   output logic                   boc_irq_req,
   output logic                   sa6_irq_req,
   output logic                   sa_change_irq_req,
   input  wire logic [6:0]        fifo_count,
   input  wire logic [6:0]        hdlc_rx_fifo_ctrl,
   input  wire logic              fifo_rd,
   input  wire logic [2:0]        pkt_status_in,
   input  wire logic [6:0]        pkt_bytes,
   input  wire logic              msg_end_in_fifo
);

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // expected bit of a repeating pattern, first byte MSB first
   function automatic logic rac_code_bit(input logic [15:0] pat, input logic [3:0] ph);
      rac_code_bit = pat[4'd15 - ph];
   endfunction

   function automatic logic [3:0] rac_len_m1(input logic [4:0] sel);
      logic [4:0] l;
      l = (sel == 5'h00) ? 5'h01 : ((sel > 5'h10) ? 5'h10 : sel);
      rac_len_m1 = 4'(l - 5'h01);
   endfunction

   localparam logic [15:0] CODE_INTEG = 16'(CODE_INTEG_BITS);
   localparam logic [9:0]  T1_CHAN    = 10'(RAC_T1_CHAN_CYCLES);
   localparam logic [9:0]  E1_CHAN    = 10'(RAC_E1_CHAN_CYCLES);
   localparam logic [7:0]  LOS_ZEROS  = 8'(RAC_LOS_ZEROS);
   localparam logic [1:0]  DMA_MF     = 2'(RAC_DMA_MULTIFRAMES);

   rac_state_type s_q;
   rac_state_type s_d;

   logic [7:0]                    live_alarm;
   logic [7:0]                    live_code;
   logic [7:0]                    live_hdlc;
   logic [7:0]                    bytes_avail;
   logic [RAC_NUM_CODES-1:0]      code_live;
   logic [RAC_NUM_CODES-1:0][15:0] code_pat;
   logic [3:0]                    len_m1;
   logic                          rx_clock_loss_live_live;
   logic                          wr_lup1;
   logic                          wr_ldn1;

   // ------------------------------------------------------------------
   // live status
   // ------------------------------------------------------------------
   always_comb begin
      len_m1   = rac_len_m1(code_len_sel);
      // second byte only counts past eight bits
      code_pat[RAC_CODE_LUP]   = {s_q.lup1, (len_m1 > 4'h7) ? s_q.lup2 : 8'h00};
      code_pat[RAC_CODE_LDN]   = {s_q.ldn1, (len_m1 > 4'h7) ? s_q.ldn2 : 8'h00};
      code_pat[RAC_CODE_SPARE] = {spare_pattern_1, (len_m1 > 4'h7) ? spare_pattern_2 : 8'h00};
      for (int i = 0; i < RAC_NUM_CODES; i++) begin
         code_live[i] = (s_q.code_cnt[i] >= CODE_INTEG);
      end
      rx_clock_loss_live_live = (s_q.rx_clock_loss_live_cnt >= (e1_mode ? E1_CHAN : T1_CHAN));
      live_alarm = 8'h00;
      live_alarm[RAC_BIT_RAI] = line.remote_alarm;
      live_alarm[RAC_BIT_AIS] = line.all_ones;
      live_alarm[RAC_BIT_LOS] = (s_q.los_cnt >= LOS_ZEROS);
      live_alarm[RAC_BIT_LOF] = line.frame_loss;
      live_code = 8'h00;
      live_code[RAC_BIT_RX_CLOCK_LOSS_LIVE] = rx_clock_loss_live_live;
      if (e1_mode) begin
         live_code[RAC_BIT_V52]  = line.v52_link;
         live_code[RAC_BIT_DISTANT_MF_ALARM_LIVE] = (s_q.dma_cnt >= DMA_MF);
      end else begin
         live_code[RAC_BIT_LSP] = code_live[RAC_CODE_SPARE];
         live_code[RAC_BIT_LDN] = code_live[RAC_CODE_LDN];
         live_code[RAC_BIT_LUP] = code_live[RAC_CODE_LUP];
      end
      live_hdlc = 8'h00;
      live_hdlc[RAC_BIT_PS_LO +: 3] = s_q.pkt_state;
      live_hdlc[RAC_BIT_HWM] = (fifo_count > hdlc_rx_fifo_ctrl);
      live_hdlc[RAC_BIT_NE]  = (fifo_count != 7'h00);
      bytes_avail = {1'b0, pkt_bytes};
      // message bit returns high once the fifo drains
      bytes_avail[RAC_BIT_MS] = (fifo_count == 7'h00) | ~msg_end_in_fifo;
   end

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      s_d     = s_q;
      wr_lup1 = bus.wr && (bus.addr == RAC_OFS_LUP_1);
      wr_ldn1 = bus.wr && (bus.addr == RAC_OFS_LDN_1);
      if (bus.wr) begin
         case (bus.addr)
            RAC_OFS_SA_IRQ_MASK: s_d.mask7     = bus.wdata;
            RAC_OFS_SIG_EN_1:    s_d.sig_en[0] = bus.wdata;
            RAC_OFS_SIG_EN_2:    s_d.sig_en[1] = bus.wdata;
            RAC_OFS_SIG_EN_3:    s_d.sig_en[2] = bus.wdata;
            RAC_OFS_SIG_EN_4:    s_d.sig_en[3] = bus.wdata;
            RAC_OFS_LUP_1:       s_d.lup1      = bus.wdata;
            RAC_OFS_LUP_2:       s_d.lup2      = bus.wdata;
            RAC_OFS_LDN_1:       s_d.ldn1      = bus.wdata;
            RAC_OFS_LDN_2:       s_d.ldn2      = bus.wdata;
            default:             s_d.mask7     = s_q.mask7;
         endcase
      end
      if (bus.rd) begin
         case (bus.addr)
            RAC_OFS_SA_IRQ_MASK: s_d.rdata = s_q.mask7;
            RAC_OFS_SIG_EN_1:    s_d.rdata = s_q.sig_en[0];
            RAC_OFS_SIG_EN_2:    s_d.rdata = s_q.sig_en[1];
            RAC_OFS_SIG_EN_3:    s_d.rdata = s_q.sig_en[2];
            RAC_OFS_SIG_EN_4:    s_d.rdata = s_q.sig_en[3];
            RAC_OFS_LUP_1:       s_d.rdata = s_q.lup1;
            RAC_OFS_LUP_2:       s_d.rdata = s_q.lup2;
            RAC_OFS_LDN_1:       s_d.rdata = s_q.ldn1;
            RAC_OFS_LDN_2:       s_d.rdata = s_q.ldn2;
            RAC_OFS_LIVE_ALARM:  s_d.rdata = live_alarm;
            RAC_OFS_LIVE_CODE:   s_d.rdata = live_code;
            RAC_OFS_LIVE_HDLC:   s_d.rdata = live_hdlc;
            RAC_OFS_BYTES_AVAIL: s_d.rdata = bytes_avail;
            default:             s_d.rdata = RAC_REG_RESET;
         endcase
      end
      // zero run for loss of signal, saturating
      if (line.bit_valid) begin
         if (line.bit_value) begin
            s_d.los_cnt = 8'h00;
         end else if (s_q.los_cnt < LOS_ZEROS) begin
            s_d.los_cnt = s_q.los_cnt + 8'h01;
         end
      end
      // silence on the receive clock pin
      s_d.clk_prev = line_rx_clock_pin;
      if (line_rx_clock_pin != s_q.clk_prev) begin
         s_d.rx_clock_loss_live_cnt = 10'h000;
      end else if (s_q.rx_clock_loss_live_cnt != 10'h3ff) begin
         s_d.rx_clock_loss_live_cnt = s_q.rx_clock_loss_live_cnt + 10'h001;
      end
      // repeating code detectors, phase follows the pattern
      for (int i = 0; i < RAC_NUM_CODES; i++) begin
         if (line.bit_valid) begin
            if (line.bit_value == rac_code_bit(code_pat[i], s_q.code_phase[i])) begin
               s_d.code_phase[i] = (s_q.code_phase[i] >= len_m1) ? 4'h0 :
                                   s_q.code_phase[i] + 4'h1;
               if (s_q.code_cnt[i] != 16'hffff) begin
                  s_d.code_cnt[i] = s_q.code_cnt[i] + 16'h0001;
               end
            end else begin
               s_d.code_phase[i] = 4'h0;
               s_d.code_cnt[i]   = 16'h0000;
            end
         end
      end
      if (wr_lup1) begin
         s_d.code_cnt[RAC_CODE_LUP]   = 16'h0000;
         s_d.code_phase[RAC_CODE_LUP] = 4'h0;
      end
      if (wr_ldn1) begin
         s_d.code_cnt[RAC_CODE_LDN]   = 16'h0000;
         s_d.code_phase[RAC_CODE_LDN] = 4'h0;
      end
      // distant multiframe alarm, counted per multiframe
      if (line.mf_valid) begin
         if (!line.mf_ts16_bit6) begin
            s_d.dma_cnt = 2'h0;
         end else if (s_q.dma_cnt < DMA_MF) begin
            s_d.dma_cnt = s_q.dma_cnt + 2'h1;
         end
      end
      if (fifo_rd) begin
         s_d.pkt_state = pkt_status_in;
      end
      s_d.sig_flag = sig_chg_valid && s_q.sig_en[sig_chg_chan[4:3]][sig_chg_chan[2:0]]
                     && (e1_mode || (sig_chg_chan < 5'(RAC_T1_CHANNELS)));
      s_d.boc_irq    = !e1_mode && boc_event && s_q.mask7[RAC_BIT_BOC_EN];
      s_d.sa6_irq    = e1_mode && sa6_event && s_q.mask7[RAC_BIT_SA6_EN];
      s_d.sa_chg_irq = e1_mode && s_q.mask7[RAC_BIT_SA_CHG_EN]
                       && |(sa_change_vec & ~sa_bit_mask_reg);
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata             = s_q.rdata;
   assign sig_change_flag   = s_q.sig_flag;
   assign boc_irq_req       = s_q.boc_irq;
   assign sa6_irq_req       = s_q.sa6_irq;
   assign sa_change_irq_req = s_q.sa_chg_irq;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_rd_alarm;
      bus.rd && bus.addr == RAC_OFS_LIVE_ALARM;
   endsequence

   sequence s_rd_code;
      bus.rd && bus.addr == RAC_OFS_LIVE_CODE;
   endsequence

   sequence s_rd_hdlc;
      bus.rd && bus.addr == RAC_OFS_LIVE_HDLC;
   endsequence

   property p_boc_gate;
      boc_irq_req |-> $past(boc_event) && !$past(e1_mode) && $past(s_q.mask7[0]);
   endproperty
   a_boc_gate: assert property (p_boc_gate) else $error("boc irq without cause");

   property p_sa6_gate;
      sa6_event && e1_mode && s_q.mask7[1] |=> sa6_irq_req;
   endproperty
   a_sa6_gate: assert property (p_sa6_gate) else $error("sa6 irq missing");

   property p_sa_chg_gate;
      sa_change_irq_req |-> $past(|(sa_change_vec & ~sa_bit_mask_reg)) && $past(e1_mode);
   endproperty
   a_sa_chg_gate: assert property (p_sa_chg_gate) else $error("sa change irq wrong");

   property p_sig_flag;
      sig_change_flag |-> $past(sig_chg_valid);
   endproperty
   a_sig_flag: assert property (p_sig_flag) else $error("signaling flag without change");

   property p_lup_restart;
      bus.wr && bus.addr == RAC_OFS_LUP_1 |=> s_q.code_cnt[RAC_CODE_LUP] == 16'h0000;
   endproperty
   a_lup_restart: assert property (p_lup_restart) else $error("loop-up not restarted");

   property p_rai_read;
      s_rd_alarm ##0 line.remote_alarm |=> rdata[RAC_BIT_RAI];
   endproperty
   a_rai_read: assert property (p_rai_read) else $error("remote alarm not read");

   property p_los_192;
      line.bit_valid && !line.bit_value && s_q.los_cnt == LOS_ZEROS - 8'h01
         |=> live_alarm[RAC_BIT_LOS];
   endproperty
   a_los_192: assert property (p_los_192) else $error("zero run not counted");

   property p_los_clear;
      line.bit_valid && line.bit_value |=> !live_alarm[RAC_BIT_LOS];
   endproperty
   a_los_clear: assert property (p_los_clear) else $error("loss of signal stuck");

   property p_rx_clock_loss_live_edge;
      line_rx_clock_pin != s_q.clk_prev |=> !rx_clock_loss_live_live;
   endproperty
   a_rx_clock_loss_live_edge: assert property (p_rx_clock_loss_live_edge) else $error("clock loss after edge");

   sequence s_mf_one;
      line.mf_valid && line.mf_ts16_bit6;
   endsequence

   sequence s_mf_gap;
      (!line.mf_valid) throughout (1'b1 ##[0:20] 1'b1);
   endsequence

   property p_dma_two;
      s_mf_one ##1 s_mf_gap ##1 s_mf_one |=> !e1_mode || live_code[RAC_BIT_DISTANT_MF_ALARM_LIVE];
   endproperty
   a_dma_two: assert property (p_dma_two) else $error("distant alarm missing");

   property p_ps_capture;
      fifo_rd |=> s_q.pkt_state == $past(pkt_status_in);
   endproperty
   a_ps_capture: assert property (p_ps_capture) else $error("packet state not captured");

   property p_ms_empty;
      fifo_count == 7'h00 |-> bytes_avail[RAC_BIT_MS];
   endproperty
   a_ms_empty: assert property (p_ms_empty) else $error("message bit low when empty");

   property p_ais_read;
      s_rd_alarm ##0 line.all_ones |=> rdata[RAC_BIT_AIS];
   endproperty
   a_ais_read: assert property (p_ais_read) else $error("all ones not read");

   property p_lof_read;
      s_rd_alarm ##0 line.frame_loss |=> rdata[RAC_BIT_LOF];
   endproperty
   a_lof_read: assert property (p_lof_read) else $error("frame loss not read");

   property p_v52_read;
      s_rd_code ##0 e1_mode && line.v52_link |=> rdata[RAC_BIT_V52];
   endproperty
   a_v52_read: assert property (p_v52_read) else $error("link not read");

   property p_hwm_read;
      s_rd_hdlc ##0 fifo_count > hdlc_rx_fifo_ctrl |=> rdata[RAC_BIT_HWM];
   endproperty
   a_hwm_read: assert property (p_hwm_read) else $error("high water not read");

   property p_ne_read;
      s_rd_hdlc ##0 fifo_count != 7'h00 |=> rdata[RAC_BIT_NE];
   endproperty
   a_ne_read: assert property (p_ne_read) else $error("not empty not read");

   property p_boc_e1;
      e1_mode |=> !boc_irq_req;
   endproperty
   a_boc_e1: assert property (p_boc_e1) else $error("code irq in e1");

   property p_sig_t1;
      sig_chg_valid && !e1_mode && sig_chg_chan >= 5'(RAC_T1_CHANNELS) |=> !sig_change_flag;
   endproperty
   a_sig_t1: assert property (p_sig_t1) else $error("t1 flag from high channel");

   property p_ldn_restart;
      bus.wr && bus.addr == RAC_OFS_LDN_1 |=> s_q.code_cnt[RAC_CODE_LDN] == 16'h0000;
   endproperty
   a_ldn_restart: assert property (p_ldn_restart) else $error("loop-down not restarted");

   property p_bytes_read;
      bus.rd && bus.addr == RAC_OFS_BYTES_AVAIL |=> rdata[6:0] == $past(pkt_bytes);
   endproperty
   a_bytes_read: assert property (p_bytes_read) else $error("byte count not read");
endmodule

// ### sim/rac_line_model.sv
/*
 * Receive line model: serial line bits and the receive clock pin.
 * Assumes the bench changes run and clk_stop away from the rising edge.
 */
module rac_line_model (
   input  wire logic        clk,
   input  wire logic        run,
   input  wire logic        clk_stop,
   input  wire logic [15:0] pattern,
   output logic             bit_valid,
   output logic             bit_value,
   output logic             rx_clock
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] idx;
   logic [1:0] div;
   initial begin
      idx = 4'h0;
      div = 2'h0;
      bit_valid = 1'b0;
      bit_value = 1'b0;
      rx_clock = 1'b0;
   end
   // bit every other cycle, pin toggles every fourth; data garbled between bits
   always @(posedge clk) begin
      div <= div + 2'h1;
      bit_valid <= run && div[0];
      bit_value <= ~bit_value;
      if (!clk_stop && div == 2'h3) begin
         rx_clock <= ~rx_clock;
      end
      if (!run) begin
         idx <= 4'h0;
      end else if (div[0]) begin
         bit_value <= pattern[4'hf - idx];
         idx <= idx + 4'h1;
      end
   end
endmodule

// ### sim/tb_rac_regs.sv
/*
 * Self-checking bench for the receive alarm, code and status registers.
 * Assumes rac_pkg, rac_regs and rac_line_model are compiled first.
 */
module tb_rac_regs
   import rac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_n, e1_mode, run, clk_stop, ra, ao, fl, v52, mfv, mfb, rd_seen;
   logic        sig_chg_valid, boc_event, sa6_event, fifo_rd, msg_end_in_fifo;
   logic        sig_change_flag, boc_irq_req, sa6_irq_req, sa_change_irq_req;
   logic [4:0]  code_len_sel, sig_chg_chan;
   logic [7:0]  spare_pattern_1, spare_pattern_2, sa_change_vec, sa_bit_mask_reg, rdata, v;
   logic [6:0]  fifo_count, hdlc_rx_fifo_ctrl, pkt_bytes;
   logic [2:0]  pkt_status_in;
   logic [15:0] pattern;
   logic [31:0] seed;
   wire logic   bv, bval, rxc;
   rac_bus_type bus;
   int          bad_count, checks_done;
   logic [7:0]  exp_q[$];
   localparam logic [7:0] RW_A [9] = '{8'ha6, 8'ha8, 8'ha9, 8'haa, 8'hab, 8'hac, 8'had,
                                       8'hae, 8'haf};

   rac_line_model model (.clk, .run, .clk_stop, .pattern, .bit_valid(bv), .bit_value(bval),
      .rx_clock(rxc));
   rac_regs #(.CODE_INTEG_BITS(4)) dut (.clk, .rst_n, .e1_mode, .bus, .rdata,
      .line({ra, ao, fl, v52, bv, bval, mfv, mfb}), .line_rx_clock_pin(rxc), .code_len_sel,
      .spare_pattern_1, .spare_pattern_2, .sig_chg_valid, .sig_chg_chan, .sig_change_flag,
      .boc_event, .sa6_event, .sa_change_vec, .sa_bit_mask_reg, .boc_irq_req, .sa6_irq_req,
      .sa_change_irq_req, .fifo_count, .hdlc_rx_fifo_ctrl, .fifo_rd, .pkt_status_in,
      .pkt_bytes, .msg_end_in_fifo);

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic cmp(input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
   endtask

   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      bus = '{rd: !w, wr: w, addr: a, wdata: d};
      @(negedge clk);
      bus.rd = 1'b0;
      bus.wr = 1'b0;
      @(negedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      acc(1'b0, a, 8'h00);
   endtask

   task automatic send_bits(input int n);
      int c;
      c = 0;
      run = 1'b1;
      for (int t = 0; t < 4 * n + 8 && c < n; t++) begin
         @(negedge clk);
         if (bv === 1'b1) c++;
      end
      run = 1'b0;
      @(negedge clk);
      if (c != n) begin
         bad_count++;
         final_report();
      end
   endtask

   task automatic ev(input logic [3:0] k, input logic [7:0] x, input logic [3:0] e);
      {sig_chg_valid, sa6_event, boc_event} = {k[3], k[1], k[0]};
      sa_change_vec = k[2] ? x : 8'h00;
      sig_chg_chan = x[4:0];
      @(negedge clk);
      {sig_chg_valid, sa6_event, boc_event, sa_change_vec} = 11'h000;
      cmp({4'h0, sig_change_flag, sa_change_irq_req, sa6_irq_req, boc_irq_req}, {4'h0, e});
      @(negedge clk);
   endtask

   task automatic rx_clock_loss_live(input int n, input logic [7:0] base);
      clk_stop = 1'b1;
      repeat (n - 10) @(negedge clk);
      rd(8'hb2, base);
      repeat (20) @(negedge clk);
      rd(8'hb2, base | 8'h08);
      clk_stop = 1'b0;
      repeat (8) @(negedge clk);
      rd(8'hb2, base);
   endtask

   task automatic mf(input logic b);
      mfb = b;
      mfv = 1'b1;
      @(negedge clk);
      mfv = 1'b0;
   endtask

   // ------------------------------------------------------------------
   // read result scoreboard
   // ------------------------------------------------------------------
   always @(posedge clk) rd_seen <= bus.rd && rst_n;
   always @(negedge clk) begin
      if (rd_seen) begin
         cmp(exp_q.pop_front(), rdata);
      end
   end

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      {rst_n, e1_mode, run, clk_stop, ra, ao, fl, v52, mfv, mfb} = 10'h000;
      {sig_chg_valid, boc_event, sa6_event, fifo_rd, msg_end_in_fifo} = 5'h00;
      {code_len_sel, sig_chg_chan, pkt_status_in, pattern} = 29'h0;
      {spare_pattern_1, spare_pattern_2, sa_change_vec, sa_bit_mask_reg} = 32'h0;
      {fifo_count, hdlc_rx_fifo_ctrl, pkt_bytes} = 21'h0;
      bus = '0;
      seed = 32'd29734;
      bad_count = 0;
      checks_done = 0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      foreach (RW_A[i]) rd(RW_A[i], 8'h00);
      rd(8'hb0, 8'h00);
      rd(8'hb2, 8'h00);
      rd(8'hb4, 8'h00);
      rd(8'hb5, 8'h80);
      foreach (RW_A[i]) begin
         v = rnd();
         acc(1'b1, RW_A[i], v);
         rd(RW_A[i], v);
      end
      acc(1'b1, 8'hb0, 8'hff);
      rd(8'hb0, 8'h00);
      rd(8'ha7, 8'h00);
      for (int i = 0; i < 4; i++) begin
         {ra, ao, fl} = 3'(rnd());
         @(negedge clk);
         rd(8'hb0, {4'h0, ra, ao, 1'b0, fl});
      end
      {ra, ao, fl} = 3'h0;
      send_bits(191);
      rd(8'hb0, 8'h00);
      send_bits(1);
      rd(8'hb0, 8'h02);
      pattern = 16'hffff;
      send_bits(1);
      rd(8'hb0, 8'h00);
      code_len_sel = 5'h04;
      {spare_pattern_1, spare_pattern_2} = {8'ha3, rnd()};
      acc(1'b1, 8'hac, 8'ha5);
      acc(1'b1, 8'had, rnd());
      acc(1'b1, 8'hae, 8'ha9);
      acc(1'b1, 8'haf, rnd());
      pattern = 16'haaaa;
      send_bits(16);
      rd(8'hb2, 8'h07);
      acc(1'b1, 8'hac, 8'ha5);
      rd(8'hb2, 8'h06);
      rx_clock_loss_live(RAC_T1_CHAN_CYCLES, 8'h06);
      acc(1'b1, 8'ha6, 8'h01);
      acc(1'b1, 8'haa, 8'h80);
      acc(1'b1, 8'hab, 8'h80);
      ev(4'h1, 8'h00, 4'h1);
      ev(4'h8, 8'h17, 4'h8);
      ev(4'h8, 8'h16, 4'h0);
      ev(4'h8, 8'h1f, 4'h0);
      acc(1'b1, 8'ha6, 8'h00);
      ev(4'h1, 8'h00, 4'h0);
      e1_mode = 1'b1;
      v52 = 1'b1;
      acc(1'b1, 8'ha6, 8'h03);
      sa_bit_mask_reg = 8'h04;
      ev(4'h2, 8'h00, 4'h2);
      ev(4'h4, 8'h04, 4'h0);
      ev(4'hc, 8'h1f, 4'hc);
      acc(1'b1, 8'ha6, 8'h00);
      ev(4'h6, 8'h08, 4'h0);
      mf(1'b1);
      rd(8'hb2, 8'h02);
      mf(1'b1);
      rd(8'hb2, 8'h03);
      rx_clock_loss_live(RAC_E1_CHAN_CYCLES, 8'h03);
      mf(1'b0);
      rd(8'hb2, 8'h02);
      for (int i = 0; i < 5; i++) begin
         fifo_count = (i == 0) ? 7'h00 : 7'(rnd() % 65);
         hdlc_rx_fifo_ctrl = 7'(rnd() % 64);
         pkt_bytes = 7'(rnd());
         msg_end_in_fifo = 1'(rnd());
         pkt_status_in = 3'(i);
         fifo_rd = 1'b1;
         @(negedge clk);
         fifo_rd = 1'b0;
         pkt_status_in = 3'h7;
         rd(8'hb4, {1'b0, 3'(i), 2'b00, fifo_count > hdlc_rx_fifo_ctrl,
            fifo_count != 7'h00});
         rd(8'hb5, {fifo_count == 7'h00 || !msg_end_in_fifo, pkt_bytes});
      end
      repeat (3) @(negedge clk);
      if (exp_q.size() != 0) bad_count++;
      final_report();
   end
endmodule
